/* File: src/adc_ext_trig_seq.sv */
// external trigger conversion sequencer with axi4-lite register slave
//
// How it works
// [RL1] conversions start only on a valid pin edge
// [RL2] software selects pin function and clears timer
// [RL3] edge field picks rising, falling or both
// [RL4] enable set: wait, then convert on trigger
// [RL5] result stored and interrupt raised together
// [RL6] after completion always return to waiting
// [RL7] active flag high converting, low waiting
// [RL8] trigger during conversion restarts the sequence
// [RL9] control register write aborts conversion to waiting
// [RL10] select modes offer one and four buffers
// [RL11] one buffer: one conversion, own index, irq
// [RL12] four buffer: four conversions into results 0-3
// [RL13] four buffer: irq only after fourth conversion
// [RL14] scan: channels 0 to selected, same index
// [RL15] scan: irq after last channel, then wait
// [RL16] enable cleared mid-conversion stores no result; a clearing write taken on the last count still stores it
// [RL17] enable never self-cleared by hardware
// [RL18] trigger source spaces triggers beyond conversion time
// [RL19] trigger pin synchronised before edge detection
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module adc_ext_trig_seq (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger pin and analog converter core
  input wire logic ext_trigger_pin,
  input wire adc_seq_pkg::conv_req_t conv_core,
  output logic [1:0] analog_input_sel,
  // status and interrupt
  output logic conv_active_flag,
  output logic conv_end_irq
);
  import adc_seq_pkg::*;

  localparam logic [7:0] CONV_LAST = 8'(`CONV_CYCLES - 1); // last count of one conversion

  // timing overview
  // the trigger pin passes two sync flops and one delayed copy, so a pin edge
  // reaches the sequencer about three cycles after it appears on the pin
  // one conversion is a fixed count of clock cycles; the converter core result
  // is taken on the last count and written to its result register; when that
  // result ends the sequence the interrupt status bit is set in the same step
  // one-buffer mode: one conversion per trigger, one interrupt per conversion
  // four-buffer mode: one conversion per trigger, the slot pointer advances
  // across triggers and the interrupt comes only with the fourth result
  // scan mode: one trigger walks channel 0 up to the selected channel without
  // stopping, and the interrupt comes after the selected channel is stored
  // a valid edge during a conversion starts the sequence again from its start;
  // the aborted result is never stored, so a source that fires too fast loses
  // results rather than corrupting them
  // a write to a control register during a conversion drops back to waiting
  // and restarts the four-buffer slot pointer, so a new setup always fills
  // slot 0 first
  // clearing the enable bit stops at once; it stores a result only when the write is taken on the last count
  // the interrupt clear is applied before the sequencer in the next-state
  // logic, so an end of conversion in the same cycle keeps the bit set

  seq_regs_t r_reg; // all state
  seq_regs_t r_next; // next state
  logic wr_fire; // write address and data both held
  logic rd_fire; // read address taken
  logic ctrl_wr; // write hits a control register
  logic conv_en; // conversion enable bit
  logic edge_rise; // synchronised rising edge
  logic edge_fall; // synchronised falling edge
  logic trig_evt; // valid trigger event
  logic ext_mode; // pin is trigger and timer trigger off
  logic scan_mode; // operation mode field selects scan
  logic last_conv; // final conversion of the sequence
  logic run_clean; // no stop, restart or control write this cycle

  assign conv_en = r_reg.mode_a[`BIT_CONV_EN];
  assign ext_mode = r_reg.mode_c[`BIT_PIN_FUNC] & ~r_reg.mode_c[`BIT_TIMER_TRIG]; // RL2
  assign scan_mode = r_reg.mode_a[`BIT_MODE_LO];
  // used by the checks: the running conversion is left alone this cycle
  assign run_clean = conv_en & ext_mode & ~trig_evt & ~ctrl_wr;
  // the second sync stage and its delayed copy are the only edge inputs
  assign edge_rise = r_reg.trig_sync[1] & ~r_reg.trig_prev; // RL19
  assign edge_fall = ~r_reg.trig_sync[1] & r_reg.trig_prev; // RL19
  // edge field: 01 rising, 00 falling, 1x both
  always_comb begin
    case ({r_reg.mode_a[`BIT_EDGE_HI], r_reg.mode_a[`BIT_EDGE_LO]})
      2'b01: trig_evt = edge_rise; // RL3
      2'b00: trig_evt = edge_fall; // RL3
      default: trig_evt = edge_rise | edge_fall; // RL3
    endcase
  end
  assign wr_fire = r_reg.awt & r_reg.wt & ~r_reg.bvalid;
  assign rd_fire = s_axi_arvalid & ~r_reg.rvalid;
  assign ctrl_wr = wr_fire & (r_reg.awaddr == `OFF_MODE_A || r_reg.awaddr == `OFF_MODE_C ||
                              r_reg.awaddr == `OFF_CHSEL);
  // end of sequence: scan reaches the selected channel, four-buffer the fourth step
  always_comb begin
    if (scan_mode) begin
      last_conv = (r_reg.idx == r_reg.chsel); // RL14
    end else if (r_reg.mode_a[`BIT_BUF4]) begin
      last_conv = (r_reg.step == 2'h3); // RL12
    end else begin
      last_conv = 1'b1; // RL11
    end
  end

  // next state of sequencer, interrupt and bus slave
  always_comb begin
    r_next = r_reg;
    r_next.trig_sync = {r_reg.trig_sync[0], ext_trigger_pin}; // RL19
    r_next.trig_prev = r_reg.trig_sync[1];
    // bus capture: address and data accepted in either order
    if (s_axi_awvalid && !r_reg.awt) begin
      r_next.awt = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_reg.wt) begin
      r_next.wt = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    // software clear of the sticky bit; done first so that a same-cycle set wins
    if (wr_fire && r_reg.awaddr == `OFF_IRQ_CLR && r_reg.wstrb[0] && r_reg.wdata[0]) begin
      r_next.irq_stat = 1'b0;
    end
    // sequencer
    case (r_reg.st)
      ST_IDLE: begin
        r_next.active = 1'b0;
        if (conv_en && ext_mode) begin
          r_next.st = ST_WAIT; // RL4
        end
      end
      ST_WAIT: begin
        r_next.active = 1'b0; // RL7
        if (!conv_en || !ext_mode) begin
          r_next.st = ST_IDLE;
        end else if (trig_evt) begin
          r_next.st = ST_CONV; // RL1
          r_next.cnt = 8'h00;
          // four-buffer keeps its slot across triggers; other modes start over
          if (scan_mode || !r_reg.mode_a[`BIT_BUF4]) begin
            r_next.step = 2'h0;
          end
          r_next.idx = scan_mode ? 2'h0 : r_reg.chsel; // RL14
          r_next.active = 1'b1; // RL7
        end
      end
      ST_CONV: begin
        r_next.cnt = r_reg.cnt + 8'h01;
        if (!conv_en || !ext_mode) begin
          r_next.st = ST_IDLE; // RL16
          r_next.active = 1'b0;
        end else if (trig_evt) begin
          r_next.cnt = 8'h00; // RL8
          r_next.step = 2'h0; // RL8
          r_next.idx = scan_mode ? 2'h0 : r_reg.chsel; // RL8
        end else if (r_reg.cnt == CONV_LAST) begin
          r_next.cnt = 8'h00;
          // four-buffer stores by step, otherwise by channel index
          if (!scan_mode && r_reg.mode_a[`BIT_BUF4]) begin
            r_next.result[r_reg.step] = conv_core.data; // RL12 RL10
            r_next.res_valid[r_reg.step] = 1'b1;
          end else begin
            r_next.result[r_reg.idx] = conv_core.data; // RL5
            r_next.res_valid[r_reg.idx] = 1'b1;
          end
          r_next.step = r_reg.step + 2'h1;
          if (scan_mode) begin
            r_next.idx = r_reg.idx + 2'h1; // RL14
          end
          if (last_conv) begin
            r_next.irq_stat = 1'b1; // RL5 RL13 RL15
            r_next.st = ST_WAIT; // RL6 RL17
            r_next.active = 1'b0; // RL7
          end else if (!scan_mode) begin
            // four-buffer: one conversion per trigger, then wait for the next
            r_next.st = ST_WAIT; // RL12
            r_next.active = 1'b0; // RL7
          end
        end
      end
      default: r_next.st = ST_IDLE;
    endcase
    // register writes
    if (wr_fire) begin
      r_next.awt = 1'b0;
      r_next.wt = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = 2'b00;
      if (r_reg.wstrb[0]) begin
        case (r_reg.awaddr)
          `OFF_MODE_A: r_next.mode_a = r_reg.wdata[5:0];
          `OFF_MODE_C: r_next.mode_c = r_reg.wdata[1:0];
          `OFF_CHSEL: r_next.chsel = r_reg.wdata[1:0];
          `OFF_IRQ_EN: r_next.irq_en = r_reg.wdata[0];
          `OFF_IRQ_CLR: r_next.irq_en = r_next.irq_en;
          default: r_next.bresp = 2'b10;
        endcase
      end
      // a new setup restarts the four-buffer slot pointer
      if (ctrl_wr) begin
        r_next.step = 2'h0;
      end
      // control writes during a conversion abort it back to waiting
      if (ctrl_wr && r_reg.st == ST_CONV) begin
        r_next.st = ST_WAIT; // RL9
        r_next.active = 1'b0; // RL9
        r_next.cnt = 8'h00;
      end
    end
    // register reads
    if (rd_fire) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = 2'b00;
      r_next.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `OFF_MODE_A: r_next.rdata = {26'h0, r_reg.mode_a};
        `OFF_MODE_C: r_next.rdata = {30'h0, r_reg.mode_c};
        `OFF_CHSEL: r_next.rdata = {30'h0, r_reg.chsel};
        `OFF_STATUS: r_next.rdata = {29'h0, r_reg.idx, r_reg.active}; // RL7
        `OFF_IRQ_STAT: r_next.rdata = {31'h0, r_reg.irq_stat};
        `OFF_IRQ_EN: r_next.rdata = {31'h0, r_reg.irq_en};
        `OFF_IRQ_CLR: r_next.rdata = 32'h0000_0000;
        8'h20, 8'h24, 8'h28, 8'h2c: r_next.rdata = {22'h0, r_reg.result[s_axi_araddr[3:2]]};
        default: r_next.rresp = 2'b10;
      endcase
    end
    r_next.irq = r_next.irq_stat & r_next.irq_en;
    r_next.chan_out = r_next.idx;
  end

  // register the whole state; synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = ~r_reg.awt;
  assign s_axi_wready = ~r_reg.wt;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = ~r_reg.rvalid;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign conv_active_flag = r_reg.active;
  assign conv_end_irq = r_reg.irq;
  assign analog_input_sel = r_reg.chan_out;

  // flag follows state
  flag_state_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
    r_reg.active == (r_reg.st == ST_CONV)) else $error("active flag mismatch");
  // no start without trigger
  start_trig_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
    (r_reg.st == ST_WAIT && !trig_evt) |=> r_reg.st != ST_CONV) else $error("start w/o trig");
  // control write aborts
  ctrl_abort_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    (ctrl_wr && r_reg.st == ST_CONV && conv_en && ext_mode) |=> r_reg.st == ST_WAIT)
    else $error("write did not abort");
  // enable never cleared by hardware
  enable_kept_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
    (conv_en && !ctrl_wr) |=> conv_en) else $error("enable self-cleared");
  // disabled abort stores nothing
  stop_nostore_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
    (r_reg.st == ST_CONV && !conv_en) |=> $stable(r_reg.res_valid)) else $error("stored on stop");
  // trigger restarts count
  trig_restart_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
    (r_reg.st == ST_CONV && conv_en && ext_mode && trig_evt && !ctrl_wr) |=> r_reg.cnt == 8'h00)
    else $error("no restart");
  // four-buffer irq not before fourth step
  buf4_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
    (r_reg.st == ST_CONV && !scan_mode && r_reg.mode_a[`BIT_BUF4] && r_reg.step != 2'h3 &&
     !r_reg.irq_stat) |=> !r_reg.irq_stat) else $error("early irq");
  // irq output tracks status and enable
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    $rose(r_reg.irq_stat) |-> (conv_end_irq == r_reg.irq_en)) else $error("irq mismatch");
  // a result register moves only on the last count
  store_at_end_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    (r_reg.cnt != CONV_LAST) |=> $stable(r_reg.result)) else $error("early result store");
  // the interrupt is set in the step that stores the result
  irq_with_store_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
    $rose(r_reg.irq_stat) |-> ($past(r_reg.cnt) == CONV_LAST)) else $error("irq without store");
  // one-buffer: every finished conversion raises the interrupt
  buf1_irq_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
    (r_reg.st == ST_CONV && !scan_mode && !r_reg.mode_a[`BIT_BUF4] &&
     r_reg.cnt == CONV_LAST && run_clean) |=> r_reg.irq_stat) else $error("missing irq");
  // a finished sequence always returns to waiting
  done_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL6 RL15
    (r_reg.st == ST_CONV && r_reg.cnt == CONV_LAST && last_conv && run_clean)
    |=> (r_reg.st == ST_WAIT && r_reg.irq_stat)) else $error("no return to wait");
  // scan moves on to the next channel until the selected one is done
  scan_next_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
    (r_reg.st == ST_CONV && scan_mode && !last_conv && r_reg.cnt == CONV_LAST && run_clean)
    |=> (r_reg.st == ST_CONV && r_reg.idx == $past(r_reg.idx) + 2'h1))
    else $error("scan did not advance");
  // four-buffer: each trigger yields one conversion, then waits
  buf4_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
    (r_reg.st == ST_CONV && !scan_mode && r_reg.mode_a[`BIT_BUF4] && !last_conv &&
     r_reg.cnt == CONV_LAST && run_clean) |=> r_reg.st == ST_WAIT) else $error("buf4 no wait");
  // a cleared enable drops to idle at once
  stop_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
    (r_reg.st == ST_CONV && !conv_en && !ctrl_wr) |=> r_reg.st == ST_IDLE)
    else $error("stop not taken");
  // trigger events come only from the synchronised edge
  sync_edge_a: assert property (@(posedge aclk) disable iff (!aresetn) // RL19
    trig_evt |-> (r_reg.trig_sync[1] != r_reg.trig_prev)) else $error("unsynced trigger");
endmodule

/* File: src/adc_seq_params.svh */
// constants for the external trigger conversion sequencer
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define OFF_MODE_A 8'h00
`define OFF_MODE_C 8'h04
`define OFF_CHSEL 8'h08
`define OFF_STATUS 8'h0c
`define OFF_IRQ_STAT 8'h10
`define OFF_IRQ_EN 8'h14
`define OFF_IRQ_CLR 8'h18
`define OFF_RESULT0 8'h20
`define BIT_CONV_EN 0
`define BIT_EDGE_LO 1
`define BIT_EDGE_HI 2
`define BIT_MODE_LO 3
`define BIT_MODE_HI 4
`define BIT_BUF4 5
`define BIT_TIMER_TRIG 0
`define BIT_PIN_FUNC 1
`define CONV_TIME_NS 3100
`define CLK_PERIOD_NS 20
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: src/adc_seq_pkg.sv */
// types for the external trigger conversion sequencer
package adc_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b11
  } seq_state_t;
  typedef struct packed {
    logic [9:0] data;
    logic [1:0] chan;
  } conv_req_t;
  typedef struct packed {
    seq_state_t st;
    logic [7:0] cnt;
    logic [1:0] idx;
    logic [1:0] step;
    logic [1:0] trig_sync;
    logic trig_prev;
    logic [5:0] mode_a;
    logic [1:0] mode_c;
    logic [1:0] chsel;
    logic [3:0][9:0] result;
    logic [3:0] res_valid;
    logic irq_stat;
    logic irq_en;
    logic irq;
    logic [1:0] chan_out;
    logic active;
    logic awt;
    logic wt;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } seq_regs_t;
endpackage

/* File: tb/adc_external_trigger_sequencer_bench.sv */
// self-checking bench for the external trigger conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module adc_external_trigger_sequencer_bench;
  import adc_seq_pkg::*;
  // bus master side
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, active, irq;
  logic [1:0] bresp, rresp, sel, rsp;
  logic [31:0] rdata, rd;
  // source commands
  logic trig = 1'b0;
  logic [7:0] level = 8'h3c;
  conv_req_t core;
  wire logic pin;
  int err_count = 0;
  int checked = 0;
  int e, k;
  always #10 aclk = ~aclk;
  adc_ext_trig_seq dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_trigger_pin(pin), .conv_core(core), .analog_input_sel(sel),
    .conv_active_flag(active), .conv_end_irq(irq));
  adc_src_model src_u (.aclk(aclk), .trig_cmd(trig), .level(level),
    .analog_input_sel(sel), .ext_trigger_pin(pin), .conv_core(core));
  // single exit point for normal end and for hangs
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // value compare, case equality so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 60);
    if (bvalid !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask
  // register read, result left in rd and rsp
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 60);
    if (rvalid !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // move the pin, then expect a conversion or none, and the interrupt or none
  task automatic fire(input logic lvl, input int lv, input logic act, input logic ix);
    int n;
    @(posedge aclk);
    level <= 8'(lv);
    trig <= lvl;
    repeat (8) @(posedge aclk);
    chk(active, act);
    n = 0;
    while (active !== 1'b0 && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    if (n == 1000) begin
      err_count++;
      report_and_stop();
    end
    repeat (2) @(posedge aclk);
    chk(irq, ix);
    if (ix) wr(`OFF_IRQ_CLR, 32'h1);
    chk(irq, 1'b0);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(irq, 1'b0);
    rdr(`OFF_STATUS);
    chk(rd, 32'h0);
    rdr(8'h40);
    chk(rsp, 2'b10);
    wr(8'h44, 32'h1);
    chk(rsp, 2'b10);
    wr(`OFF_MODE_C, 32'h2);
    wr(`OFF_IRQ_EN, 32'h1);
    wr(`OFF_CHSEL, 32'h2);
    fire(1'b1, 8'h11, 1'b0, 1'b0);
    // falling, rising, both: wrong edge must be ignored
    for (e = 0; e < 3; e++) begin
      wr(`OFF_MODE_A, 32'((e << 1) | 1));
      fire(1'b0, 8'h20 + e, e != 1, e != 1);
      fire(1'b1, 8'h30 + e, e != 0, e != 0);
    end
    rdr(`OFF_RESULT0 + 8'h08);
    chk(rd, {2'h2, 8'h32});
    rdr(`OFF_MODE_A);
    chk(rd[0], 1'b1);
    // a second edge mid-conversion restarts the count
    @(posedge aclk);
    trig <= 1'b0;
    repeat (60) @(posedge aclk);
    trig <= 1'b1;
    repeat (120) @(posedge aclk);
    chk(active, 1'b1);
    fire(1'b1, 8'h44, 1'b1, 1'b1);
    rdr(`OFF_RESULT0 + 8'h08);
    chk(rd, {2'h2, 8'h44});
    // channel select write mid-conversion drops back to waiting
    @(posedge aclk);
    trig <= 1'b0;
    repeat (30) @(posedge aclk);
    wr(`OFF_CHSEL, 32'h2);
    fire(1'b0, 8'h55, 1'b0, 1'b0);
    // enable cleared mid-conversion stores nothing
    @(posedge aclk);
    trig <= 1'b1;
    repeat (30) @(posedge aclk);
    wr(`OFF_MODE_A, 32'h4);
    fire(1'b0, 8'h66, 1'b0, 1'b0);
    rdr(`OFF_RESULT0 + 8'h08);
    chk(rd, {2'h2, 8'h44});
    // four buffers: one result per trigger, interrupt only after the fourth
    wr(`OFF_CHSEL, 32'h1);
    wr(`OFF_MODE_A, 32'h25);
    for (k = 0; k < 4; k++) fire(~k[0], 8'h70 + k, 1'b1, k == 3);
    for (k = 0; k < 4; k++) begin
      rdr(`OFF_RESULT0 + 8'(4 * k));
      chk(rd, {2'h1, 8'(8'h70 + k)});
    end
    // scan from channel 0 to the selected last channel
    wr(`OFF_CHSEL, 32'h3);
    wr(`OFF_MODE_A, 32'h0d);
    fire(1'b1, 8'h90, 1'b1, 1'b1);
    for (k = 0; k < 4; k++) begin
      rdr(`OFF_RESULT0 + 8'(4 * k));
      chk(rd, {2'(k), 8'h90});
    end
    fire(1'b0, 8'h91, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule

/* File: tb/adc_src_model.sv */
// model of the external trigger source and the analog inputs
`timescale 1ns/1ps
module adc_src_model (
  // clock
  input wire logic aclk,
  // bench commands
  input wire logic trig_cmd,
  input wire logic [7:0] level,
  // converter side
  input wire logic [1:0] analog_input_sel,
  output logic ext_trigger_pin,
  output adc_seq_pkg::conv_req_t conv_core
);
  import adc_seq_pkg::*;
  // pin moves just after an edge, as a source clocked off the same system clock would
  always_ff @(posedge aclk) begin
    ext_trigger_pin <= trig_cmd;
  end
  // each input shows its channel number above a bench-set level, so stores are traceable
  assign conv_core = '{data: {analog_input_sel, level}, chan: analog_input_sel};
endmodule
